// file: src/rcpp_core.sv
// Purpose: transmit request scheduler for two request channels, preemption and prestaging
// Assumes: one frame per loaded request, request held level until its done pulse
// Notes: output FIFO holds words of the current frame only
`default_nettype none
`include "rcpp_regs.svh"

module rcpp_core #(
    parameter int FIFO_DEPTH = 1024,
    parameter int LEN_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req0_valid,
    input wire logic req0_immediate,
    input wire logic [LEN_W-1:0] req0_words,
    output logic req0_done,
    input wire logic req1_valid,
    input wire logic req1_immediate,
    input wire logic [LEN_W-1:0] req1_words,
    output logic req1_done,
    output logic fetch_valid,
    output logic fetch_chan,
    output logic [LEN_W-1:0] fetch_index,
    input wire logic fetch_ready,
    input wire logic [31:0] fetch_data,
    input wire logic token_captured,
    output logic token_release,
    output logic token_held,
    output logic tx_valid,
    output logic [31:0] tx_data,
    output logic tx_last,
    output logic tx_chan,
    input wire logic tx_ready
);
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int FW = AW + 1;

    // the largest threshold must fit, and pointers wrap only on a power of two
    if (FIFO_DEPTH < `RCPP_THR_MAX || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0
        || LEN_W < 2) begin : g_bad_cfg
        $error("rcpp_core: FIFO_DEPTH must be a power of two >= 512");
    end

    typedef struct packed {
        logic aw_got;
        logic [5:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] cfg0a;
        logic [7:0] cfg1a;
        logic [7:0] cfg0b;
        logic [7:0] cfg1b;
        rcpp_pkg::rcpp_state_e state;
        logic cur;
        logic held;
        logic release_p;
        logic done0;
        logic done1;
        logic [FW-1:0] fill;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [LEN_W-1:0] fetched;
        logic [LEN_W-1:0] sent;
    } rcpp_state_s;

    rcpp_state_s st_reg;
    rcpp_state_s st_next;
    logic [31:0] fifo_mem [FIFO_DEPTH];

    // ==========================================================
    // helpers
    function automatic rcpp_pkg::rcpp_sel_e rcpp_decode(input logic [5:0] addr);
        if (addr == `RCPP_OFF_CH0_CFG_A) begin
            return rcpp_pkg::RCPP_SEL_C0A;
        end else if (addr == `RCPP_OFF_CH1_CFG_A) begin
            return rcpp_pkg::RCPP_SEL_C1A;
        end else if (addr == `RCPP_OFF_CH0_CFG_B) begin
            return rcpp_pkg::RCPP_SEL_C0B;
        end else if (addr == `RCPP_OFF_CH1_CFG_B) begin
            return rcpp_pkg::RCPP_SEL_C1B;
        end else if (addr == `RCPP_OFF_STATUS) begin
            return rcpp_pkg::RCPP_SEL_STAT;
        end else begin
            return rcpp_pkg::RCPP_SEL_NONE;
        end
    endfunction : rcpp_decode

    // channel zero ignores the hold bit here; immediate class never stages
    function automatic logic rcpp_prestage(input logic ch, input logic imm, input logic [7:0] cfg1);
        return !imm && (!ch || cfg1[`RCPP_CFGA_PRE] || !cfg1[`RCPP_CFGA_HLD]);
    endfunction : rcpp_prestage

    // bit 10 flags end-of-frame; reserved codes fall back to end-of-frame
    function automatic logic [10:0] rcpp_threshold(input logic [1:0] tt, input logic extended_threshold_bit);
        case ({extended_threshold_bit, tt})
            3'h0: return {1'b0, `RCPP_THR_8};
            3'h1: return {1'b0, `RCPP_THR_16};
            3'h2: return {1'b0, `RCPP_THR_128};
            3'h3: return {1'b0, `RCPP_THR_256};
            3'h4: return {1'b0, `RCPP_THR_512};
            default: return {1'b1, 10'h000};
        endcase
    endfunction : rcpp_threshold

    // ==========================================================
    // current channel view
    logic [7:0] cfg_cur;
    logic eft_cur;
    logic [LEN_W-1:0] len_cur;
    logic imm_cur;
    logic preempt_en;
    logic [10:0] thr_cur;
    logic fetch_on;
    logic push;
    logic pop;
    logic last_word;

    assign cfg_cur = st_reg.cur ? st_reg.cfg1a : st_reg.cfg0a;
    assign eft_cur = st_reg.cur ? st_reg.cfg1b[`RCPP_CFGB_EFT] : st_reg.cfg0b[`RCPP_CFGB_EFT];
    assign len_cur = st_reg.cur ? req1_words : req0_words;
    assign imm_cur = st_reg.cur ? req1_immediate : req0_immediate;
    assign preempt_en = st_reg.cfg0a[`RCPP_CFGA_PRE];
    assign thr_cur = rcpp_threshold(cfg_cur[`RCPP_CFGA_TT_HI:`RCPP_CFGA_TT_LO], eft_cur);
    assign fetch_on = st_reg.state == rcpp_pkg::RCPP_STAGE || st_reg.state == rcpp_pkg::RCPP_FILL
        || st_reg.state == rcpp_pkg::RCPP_XMIT;
    assign fetch_valid = fetch_on && st_reg.fetched < len_cur && st_reg.fill < FW'(FIFO_DEPTH);
    assign push = fetch_valid && fetch_ready;
    assign tx_valid = st_reg.state == rcpp_pkg::RCPP_XMIT && st_reg.fill != '0;
    assign pop = tx_valid && tx_ready;
    assign last_word = st_reg.sent == len_cur - LEN_W'(1);

    // ==========================================================
    // output ports
    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign fetch_chan = st_reg.cur;
    assign fetch_index = st_reg.fetched;
    assign tx_chan = st_reg.cur;
    assign tx_last = tx_valid && last_word;
    assign tx_data = fifo_mem[st_reg.rptr];
    assign token_release = st_reg.release_p;
    assign token_held = st_reg.held;
    assign req0_done = st_reg.done0;
    assign req1_done = st_reg.done1;

    // ==========================================================
    // next state
    always_comb begin
        rcpp_pkg::rcpp_sel_e wsel;
        rcpp_pkg::rcpp_sel_e rsel;
        logic other_req;
        logic thr_met;
        wsel = rcpp_decode(st_reg.awaddr);
        rsel = rcpp_decode(s_axi_araddr);
        other_req = st_reg.cur ? (req0_valid && req0_words != '0)
            : (req1_valid && req1_words != '0);
        thr_met = thr_cur[10] ? 1'b0 : st_reg.fill >= FW'(thr_cur[9:0]);
        st_next = st_reg;
        st_next.release_p = 1'b0;
        st_next.done0 = 1'b0;
        st_next.done1 = 1'b0;

        // write channel: address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata[7:0];
            st_next.wstrb0 = s_axi_wstrb[0];
        end
        if (st_reg.aw_got && st_reg.w_got) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `RCPP_RESP_OKAY;
            // changing config mid-request is software's hazard, not guarded
            if (wsel == rcpp_pkg::RCPP_SEL_NONE) begin
                st_next.bresp = `RCPP_RESP_DECERR;
            end else if (st_reg.wstrb0) begin
                case (wsel)
                    rcpp_pkg::RCPP_SEL_C0A: st_next.cfg0a = st_reg.wdata;
                    rcpp_pkg::RCPP_SEL_C1A: st_next.cfg1a = st_reg.wdata;
                    rcpp_pkg::RCPP_SEL_C0B: st_next.cfg0b = st_reg.wdata;
                    rcpp_pkg::RCPP_SEL_C1B: st_next.cfg1b = st_reg.wdata;
                    default: ;
                endcase
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // read channel
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `RCPP_RESP_OKAY;
            st_next.rdata = '0;
            case (rsel)
                rcpp_pkg::RCPP_SEL_C0A: st_next.rdata[7:0] = st_reg.cfg0a;
                rcpp_pkg::RCPP_SEL_C1A: st_next.rdata[7:0] = st_reg.cfg1a;
                rcpp_pkg::RCPP_SEL_C0B: st_next.rdata[7:0] = st_reg.cfg0b;
                rcpp_pkg::RCPP_SEL_C1B: st_next.rdata[7:0] = st_reg.cfg1b;
                rcpp_pkg::RCPP_SEL_STAT: begin
                    st_next.rdata[`RCPP_ST_STATE_LO +: 3] = st_reg.state;
                    st_next.rdata[`RCPP_ST_CUR_CH] = st_reg.cur;
                    st_next.rdata[`RCPP_ST_TOKEN] = st_reg.held;
                    st_next.rdata[`RCPP_ST_FILL_LO +: FW] = st_reg.fill;
                end
                default: st_next.rresp = `RCPP_RESP_DECERR;
            endcase
        end

        // fifo bookkeeping
        if (push) begin
            st_next.wptr = st_reg.wptr + AW'(1);
            st_next.fetched = st_reg.fetched + LEN_W'(1);
        end
        if (pop) begin
            st_next.rptr = st_reg.rptr + AW'(1);
            st_next.sent = st_reg.sent + LEN_W'(1);
        end
        st_next.fill = st_reg.fill + FW'(push) - FW'(pop);

        // request machine
        case (st_reg.state)
            rcpp_pkg::RCPP_IDLE: begin
                st_next.fetched = '0;
                st_next.sent = '0;
                // a request still up during its own done pulse is already served
                if (req0_valid && req0_words != '0 && !st_reg.done0) begin
                    st_next.cur = 1'b0;
                    st_next.state = rcpp_prestage(1'b0, req0_immediate, st_reg.cfg1a)
                        ? rcpp_pkg::RCPP_STAGE : rcpp_pkg::RCPP_WAIT_TOKEN;
                end else if (req1_valid && req1_words != '0 && !st_reg.done1) begin
                    st_next.cur = 1'b1;
                    st_next.state = rcpp_prestage(1'b1, req1_immediate, st_reg.cfg1a)
                        ? rcpp_pkg::RCPP_STAGE : rcpp_pkg::RCPP_WAIT_TOKEN;
                end
            end
            rcpp_pkg::RCPP_STAGE: begin
                if (st_reg.cur && req0_valid && req0_words != '0 && preempt_en) begin
                    // uncommitted frame dropped; request stays loaded so it refetches whole
                    st_next.rptr = st_next.wptr;
                    st_next.fill = '0;
                    st_next.fetched = '0;
                    st_next.state = rcpp_pkg::RCPP_IDLE;
                end else if (token_captured) begin
                    st_next.held = 1'b1;
                    st_next.state = rcpp_pkg::RCPP_FILL;
                end
            end
            rcpp_pkg::RCPP_WAIT_TOKEN: begin
                if (token_captured) begin
                    if (st_reg.cur && st_reg.fill == '0 && !req0_valid
                        && !st_reg.cfg1a[`RCPP_CFGA_HLD]) begin
                        st_next.release_p = 1'b1;
                        st_next.state = rcpp_pkg::RCPP_IDLE;
                    end else begin
                        st_next.held = 1'b1;
                        st_next.state = rcpp_pkg::RCPP_FILL;
                    end
                end
            end
            rcpp_pkg::RCPP_FILL: begin
                if (thr_met || (st_reg.fetched == len_cur && st_reg.fill != '0)) begin
                    st_next.state = rcpp_pkg::RCPP_XMIT;
                end
            end
            rcpp_pkg::RCPP_XMIT: begin
                if (pop && last_word) begin
                    st_next.done0 = !st_reg.cur;
                    st_next.done1 = st_reg.cur;
                    st_next.sent = '0;
                    st_next.fetched = '0;
                    if (st_reg.cur && req0_valid && preempt_en) begin
                        // reprioritise: channel zero gets the next opportunity
                        st_next.release_p = 1'b1;
                        st_next.held = 1'b0;
                        st_next.state = rcpp_pkg::RCPP_IDLE;
                    end else if (!cfg_cur[`RCPP_CFGA_HLD] && other_req) begin
                        st_next.cur = !st_reg.cur;
                        st_next.state = rcpp_pkg::RCPP_FILL;
                    end else begin
                        st_next.release_p = 1'b1;
                        st_next.held = 1'b0;
                        st_next.state = rcpp_pkg::RCPP_IDLE;
                    end
                end
            end
            default: st_next.state = rcpp_pkg::RCPP_IDLE;
        endcase
        if (st_next.release_p) begin
            st_next.held = 1'b0;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.state <= rcpp_pkg::RCPP_IDLE;
            st_reg.cfg0a <= `RCPP_CFGA_RESET;
            st_reg.cfg1a <= `RCPP_CFGA_RESET;
            st_reg.cfg0b <= `RCPP_CFGB_RESET;
            st_reg.cfg1b <= `RCPP_CFGB_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // payload store kept outside the state word; it needs no reset
    always_ff @(posedge aclk) begin
        if (push) begin
            fifo_mem[st_reg.wptr] <= fetch_data;
        end
    end
endmodule : rcpp_core

`default_nettype wire

// file: src/rcpp_regs.svh
// Purpose: register map, field positions and reset values of the request scheduler
// Assumes: AXI4-Lite, one aligned 32-bit word per register
// Notes: byte addresses; config registers carry 8 live bits in the low byte
`ifndef RCPP_REGS_SVH
`define RCPP_REGS_SVH

// ==========================================================
// offsets
`define RCPP_OFF_CH0_CFG_A 6'h00
`define RCPP_OFF_CH1_CFG_A 6'h04
`define RCPP_OFF_CH0_CFG_B 6'h08
`define RCPP_OFF_CH1_CFG_B 6'h0c
`define RCPP_OFF_STATUS 6'h10

// ==========================================================
// config_a fields
`define RCPP_CFGA_TT_HI 7
`define RCPP_CFGA_TT_LO 6
`define RCPP_CFGA_PRE 5
`define RCPP_CFGA_HLD 4
// config_b fields
`define RCPP_CFGB_EFT 0

// ==========================================================
// status fields
`define RCPP_ST_STATE_LO 0
`define RCPP_ST_CUR_CH 4
`define RCPP_ST_TOKEN 5
`define RCPP_ST_FILL_LO 16

// ==========================================================
// reset values and thresholds in words
`define RCPP_CFGA_RESET 8'h00
`define RCPP_CFGB_RESET 8'h00
`define RCPP_THR_8 10'h008
`define RCPP_THR_16 10'h010
`define RCPP_THR_128 10'h080
`define RCPP_THR_256 10'h100
`define RCPP_THR_512 10'h200
`define RCPP_THR_MAX 512

// ==========================================================
// bus answers
`define RCPP_RESP_OKAY 2'h0
`define RCPP_RESP_DECERR 2'h3

`endif

// file: src/rcpp_pkg.sv
// Purpose: shared types of the request scheduler
// Assumes: nothing beyond the register header
// Notes: state order sets the state code read from the status register
`default_nettype none

package rcpp_pkg;
    // ==========================================================
    // request machine states
    typedef enum logic [2:0] {
        RCPP_IDLE,
        RCPP_STAGE,
        RCPP_WAIT_TOKEN,
        RCPP_FILL,
        RCPP_XMIT
    } rcpp_state_e;

    // register selector
    typedef enum logic [2:0] {
        RCPP_SEL_C0A,
        RCPP_SEL_C1A,
        RCPP_SEL_C0B,
        RCPP_SEL_C1B,
        RCPP_SEL_STAT,
        RCPP_SEL_NONE
    } rcpp_sel_e;
endpackage : rcpp_pkg

`default_nettype wire

// file: tb/rcpp_monitor.sv
// Purpose: port-level checks of the request scheduler
// Assumes: one clock, aresetn synchronous active low
// Notes: bound into every rcpp_core instance
`default_nettype none

module rcpp_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic req0_valid,
    input wire logic req0_immediate,
    input wire logic req0_done,
    input wire logic req1_valid,
    input wire logic req1_immediate,
    input wire logic req1_done,
    input wire logic fetch_valid,
    input wire logic fetch_chan,
    input wire logic token_held,
    input wire logic token_release,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_last,
    input wire logic tx_chan
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ====
    // register bus
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");

    // ====
    // scheduling
    a_tx_token: assert property (tx_valid |-> token_held)
        else $error("transmit without token");
    a_imm_unstaged: assert property (fetch_valid && !token_held |->
        !(fetch_chan ? req1_immediate : req0_immediate)) else $error("immediate staged");
    a_fetch_owner: assert property (fetch_valid |-> (fetch_chan ? req1_valid : req0_valid))
        else $error("fetch without request");
    a_done_zero: assert property (req0_done |->
        $past(tx_valid && tx_ready && tx_last && !tx_chan)) else $error("done0 misplaced");
    a_done_one: assert property (req1_done |->
        $past(tx_valid && tx_ready && tx_last && tx_chan)) else $error("done1 misplaced");
    a_release_pulse: assert property (token_release |=> !token_release)
        else $error("release not a pulse");
endmodule : rcpp_monitor

bind rcpp_core rcpp_monitor u_rcpp_monitor (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .req0_valid(req0_valid),
    .req0_immediate(req0_immediate), .req0_done(req0_done), .req1_valid(req1_valid),
    .req1_immediate(req1_immediate), .req1_done(req1_done), .fetch_valid(fetch_valid),
    .fetch_chan(fetch_chan), .token_held(token_held), .token_release(token_release),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last), .tx_chan(tx_chan)
);

`default_nettype wire

// file: tb/rcpp_far_end.sv
// Purpose: host memory and ring token partner of the scheduler
// Assumes: memory word is a pattern of channel and index
// Notes: ready lines stall at random
`default_nettype none

module rcpp_far_end (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic offer_token,
    input wire logic fetch_valid,
    input wire logic fetch_chan,
    input wire logic [15:0] fetch_index,
    input wire logic token_held,
    output logic fetch_ready,
    output logic [31:0] fetch_data,
    output logic token_captured,
    output logic tx_ready
);
    logic [31:0] word;

    assign word = {8'h5a, 7'h00, fetch_chan, fetch_index};
    // idle bus shows the inverse so stale data cannot pass
    assign fetch_data = fetch_valid ? word : ~word;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_ready <= 1'b0;
            tx_ready <= 1'b0;
            token_captured <= 1'b0;
        end else begin
            fetch_ready <= ($urandom % 4) != 0;
            tx_ready <= ($urandom % 3) != 0;
            // one pulse per pass while the ring offers the token
            token_captured <= offer_token && !token_held && !token_captured;
        end
    end
endmodule : rcpp_far_end

`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench of the request scheduler
// Assumes: far-end model supplies memory words and the token
// Notes: random lengths and stalls from a fixed seed
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic offer = 1'b0;
    logic [1:0] rv = 2'h0, ri = 2'h0;
    logic [15:0] len [2] = '{16'h0, 16'h0};
    logic awready, wready, bvalid, arready, rvalid, fetch_valid, fetch_chan, fetch_ready;
    logic token_captured, token_release, token_held, tx_valid, tx_last, tx_chan, tx_ready;
    logic req0_done, req1_done;
    logic [1:0] bresp, rresp;
    logic [15:0] fetch_index;
    logic [31:0] rdata, fetch_data, tx_data;
    int n_errors = 0, checks_done = 0, thr = 0, rel = 0;
    int fcnt [2] = '{0, 0};
    int tcnt [2] = '{0, 0};
    // {channel, immediate, prestage expected, config_a}
    logic [10:0] modes [8] = '{11'h100, 11'h120, 11'h520, 11'h530,
        11'h500, 11'h410, 11'h200, 11'h610};

    always #50 aclk = ~aclk;

    rcpp_core u_rcpp_core (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .req0_valid(rv[0]), .req0_immediate(ri[0]), .req0_words(len[0]), .req0_done(req0_done),
        .req1_valid(rv[1]), .req1_immediate(ri[1]), .req1_words(len[1]), .req1_done(req1_done),
        .fetch_valid(fetch_valid), .fetch_chan(fetch_chan), .fetch_index(fetch_index),
        .fetch_ready(fetch_ready), .fetch_data(fetch_data), .token_captured(token_captured),
        .token_release(token_release), .token_held(token_held), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_chan(tx_chan), .tx_ready(tx_ready)
    );

    rcpp_far_end u_rcpp_far_end (
        .aclk(aclk), .aresetn(aresetn), .offer_token(offer), .fetch_valid(fetch_valid),
        .fetch_chan(fetch_chan), .fetch_index(fetch_index), .token_held(token_held),
        .fetch_ready(fetch_ready), .fetch_data(fetch_data), .token_captured(token_captured),
        .tx_ready(tx_ready)
    );

    // ====
    // checking and bus tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task conclude;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task hang;
        n_errors++;
        conclude();
    endtask : hang

    task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) hang();
        chk(bresp, er);
    endtask : wr

    task rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) hang();
        chk(rdata, ed);
        chk(rresp, er);
    endtask : rd

    // the done pulse is the requester's cue to drop its level
    task wait_idle(input int ch);
        int n;
        for (n = 0; n < 5000 && !(ch ? req1_done : req0_done); n++) @(posedge aclk);
        if (n == 5000) hang();
        rv[ch] <= 1'b0;
    endtask : wait_idle

    function automatic int exp_thr(input logic [1:0] tt, input bit extended_threshold_bit, input int n);
        int t;
        // reserved codes with the extended bit run as end of frame
        t = extended_threshold_bit ? (tt == 2'h0 ? 512 : n) : (tt == 2'h0 ? 8 : tt == 2'h1 ? 16 :
            tt == 2'h2 ? 128 : 256);
        return t < n ? t : n;
    endfunction : exp_thr

    task frame(input int ch, input logic [7:0] cfg, input bit extended_threshold_bit, input bit imm,
        input bit pre, input int n);
        wr(ch ? 6'h04 : 6'h00, {24'h0, cfg}, 2'h0);
        wr(ch ? 6'h0c : 6'h08, {31'h0, extended_threshold_bit}, 2'h0);
        thr = exp_thr(cfg[7:6], extended_threshold_bit, n);
        fcnt[ch] = 0;
        tcnt[ch] = 0;
        len[ch] <= 16'(n);
        rv[ch] <= 1'b1;
        ri[ch] <= imm;
        repeat (40) @(posedge aclk);
        chk(fcnt[ch] > 0, pre);
        offer <= 1'b1;
        wait_idle(ch);
        offer <= 1'b0;
        chk(tcnt[ch], n);
    endtask : frame

    // ====
    // stream watch: order, data, threshold
    always @(posedge aclk) begin
        if (aresetn && tx_valid && tx_ready) begin
            if (tcnt[tx_chan] == 0) chk(fcnt[tx_chan] >= thr, 1);
            chk(tx_data, {8'h5a, 7'h00, tx_chan, tcnt[tx_chan][15:0]});
            chk(tx_last, tcnt[tx_chan] == len[tx_chan] - 1);
            tcnt[tx_chan]++;
        end
        if (aresetn && fetch_valid && fetch_ready) fcnt[fetch_chan]++;
        if (aresetn && token_release) rel++;
    end

    initial begin
        int i;
        i = $urandom(32'hdced);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 5; i++) rd(6'(4 * i), 32'h0, 2'h0);
        wr(6'h04, 32'hffffffa5, 2'h0);
        rd(6'h04, 32'h000000a5, 2'h0);
        wr(6'h14, 32'h1, 2'h3);
        rd(6'h14, 32'h0, 2'h3);
        for (i = 0; i < 8; i++) begin
            frame(modes[i][10], modes[i][7:0], 1'b0, modes[i][9], modes[i][8], 1 + $urandom % 60);
        end
        for (i = 0; i < 8; i++) begin
            frame(1, {i[1:0], 6'h10}, i[2], 1'b0, 1'b0, 1 + $urandom % 600);
        end
        // staged channel one frame overtaken by channel zero
        thr = 0;
        wr(6'h00, 32'h20, 2'h0);
        wr(6'h04, 32'h30, 2'h0);
        fcnt = '{0, 0};
        tcnt = '{0, 0};
        ri <= 2'h0;
        len[1] <= 16'd20;
        rv[1] <= 1'b1;
        repeat (40) @(posedge aclk);
        len[0] <= 16'd10;
        rv[0] <= 1'b1;
        repeat (40) @(posedge aclk);
        offer <= 1'b1;
        wait_idle(0);
        chk(tcnt[1], 0);
        wait_idle(1);
        chk(tcnt[1], 20);
        // channel zero arriving while channel one transmits
        tcnt = '{0, 0};
        len[1] <= 16'd300;
        rv[1] <= 1'b1;
        for (i = 0; i < 3000 && tcnt[1] < 4; i++) @(posedge aclk);
        if (tcnt[1] < 4) hang();
        len[0] <= 16'd5;
        rv[0] <= 1'b1;
        offer <= 1'b0;
        wait_idle(1);
        repeat (20) @(posedge aclk);
        chk(token_held, 1'b0);
        chk(tcnt[0], 0);
        offer <= 1'b1;
        wait_idle(0);
        chk(tcnt[0], 5);
        // channel one, immediate, hold clear: token goes straight back
        wr(6'h04, 32'h0, 2'h0);
        tcnt = '{0, 0};
        ri <= 2'h2;
        len[1] <= 16'd4;
        rv[1] <= 1'b1;
        i = rel;
        repeat (40) @(posedge aclk);
        chk(rel > i, 1);
        chk(tcnt[1], 0);
        conclude();
    end
endmodule : testbench

`default_nettype wire
